// ===== logic/pwmb_pkg.sv
// Constants for the four-channel PWM with brake.
// Assumes an Avalon-MM byte address, one 8-bit register per 32-bit word.
package pwmb_pkg;
  localparam int CNT_W  = 10;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 10;
  localparam int NCH    = 4;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PERIOD   = 8'hd9;
  localparam logic [7:0] IDX_CMP0     = 8'hda;
  localparam logic [7:0] IDX_CMP1     = 8'hdb;
  localparam logic [7:0] IDX_CTRL1    = 8'hdc;
  localparam logic [7:0] IDX_CMP2     = 8'hdd;
  localparam logic [7:0] IDX_CMP3     = 8'hde;
  localparam logic [7:0] IDX_CTRL2    = 8'hdf;
  localparam logic [7:0] IDX_PER_HI   = 8'he4;
  localparam logic [7:0] IDX_CMP_HI   = 8'he5;
  localparam logic [7:0] IDX_IRQ_STAT = 8'he6;
  localparam logic [7:0] IDX_IRQ_MASK = 8'he7;

  // Control one fields
  localparam int C1_RUN   = 7;
  localparam int C1_LOAD  = 6;
  localparam int C1_UF    = 5;
  localparam int C1_CLR   = 4;
  // Control two fields
  localparam int C2_MODE  = 7;
  localparam int C2_POL   = 6;
  localparam int C2_SRC   = 5;
  localparam int C2_EN    = 4;
  // Interrupt status and mask fields
  localparam int IRQ_UF   = 0;
  localparam int IRQ_PIN  = 1;
  localparam int IRQ_W    = 2;

  localparam logic [7:0]  RESET_BYTE = 8'h00;
  localparam logic [9:0]  CNT_ZERO   = 10'h000;
  localparam logic [9:0]  CNT_WRAP   = 10'h3ff;

  typedef enum logic [1:0] {
    BRK_SOFT = 2'b00,
    BRK_IDLE = 2'b01,
    BRK_PIN  = 2'b10,
    BRK_NONE = 2'b11
  } pwmb_brake_sel_type;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } pwmb_bus_state_type;
endpackage

// ===== logic/pwmb_top.sv
// Four-channel PWM with shared 10-bit down-counter and brake.
// Assumes an Avalon-MM master on core_clk_in and a synchronous brake pin.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module pwmb_top (
  input  wire logic                         core_clk_in,
  input  wire logic                         reset_in,
  input  wire logic [pwmb_pkg::ADDR_W-1:0]  avs_address_in,
  input  wire logic                         avs_read_in,
  input  wire logic                         avs_write_in,
  input  wire logic [3:0]                   avs_byteenable_in,
  input  wire logic [31:0]                  avs_writedata_in,
  output logic      [31:0]                  avs_readdata_out,
  output logic                              avs_waitrequest_out,
  input  wire logic                         brake_pin_in,
  output logic      [pwmb_pkg::NCH-1:0]     pwm_out,
  output logic                              irq_out
);
  import pwmb_pkg::*;

  typedef struct packed {
    pwmb_bus_state_type       bus;
    logic [DATA_W-1:0]        rdata;
    logic [DATA_W-1:0]        ctrl1;
    logic [DATA_W-1:0]        ctrl2;
    logic [DATA_W-1:0]        period;
    logic [1:0]               per_hi;
    logic [NCH*DATA_W-1:0]    cmp_lo;
    logic [2*NCH-1:0]         cmp_hi;
    logic [CNT_W-1:0]         counter;
    logic [NCH*CNT_W-1:0]     cmp_work;
    logic                     load_done;
    logic [IRQ_W-1:0]         irq_stat;
    logic [IRQ_W-1:0]         irq_mask;
    logic [NCH-1:0]           pwm;
  } pwmb_state_type;

  pwmb_state_type state_ff;
  pwmb_state_type nxt_state;

  logic               acc;
  logic               wr_acc;
  logic [7:0]         idx;
  logic [DATA_W-1:0]  wbyte;
  logic               underflow;
  logic               pin_active;
  logic               brake;
  logic               pin_brake;
  logic [NCH-1:0]     raw;
  pwmb_brake_sel_type sel;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign acc    = (avs_read_in | avs_write_in) && state_ff.bus == BUS_ACK;
  assign wr_acc = acc && avs_write_in && avs_byteenable_in[0];
  assign idx    = avs_address_in[ADDR_W-1:2];
  assign wbyte  = avs_writedata_in[DATA_W-1:0];
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) &&
                               state_ff.bus == BUS_IDLE;
  assign avs_readdata_out = {{(32-DATA_W){1'b0}}, state_ff.rdata};

  ////////////////////////////////////////////////////////////////////////////
  // Brake condition
  assign sel        = pwmb_brake_sel_type'({state_ff.ctrl2[C2_SRC],
                                            state_ff.ctrl2[C2_MODE]});
  assign pin_active = brake_pin_in == state_ff.ctrl2[C2_POL];
  always_comb begin
    brake     = 1'b0;
    pin_brake = 1'b0;
    if (state_ff.ctrl2[C2_EN]) begin
      case (sel)
        BRK_SOFT: brake = 1'b1;
        BRK_IDLE: brake = !state_ff.ctrl1[C1_RUN];
        BRK_PIN: begin
          brake     = pin_active;
          pin_brake = pin_active;
        end
        BRK_NONE: brake = 1'b0;
        default:  brake = 1'b0;
      endcase
    end
  end

  assign underflow = state_ff.ctrl1[C1_RUN] && state_ff.counter == CNT_ZERO;

  // Raw waveform: high while counter is below the channel comparator
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_cmp
      assign raw[g] = state_ff.counter <
                      state_ff.cmp_work[g*CNT_W +: CNT_W];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_state = state_ff;
    nxt_state.bus = ((avs_read_in | avs_write_in) &&
                     state_ff.bus == BUS_IDLE) ? BUS_ACK : BUS_IDLE;
    nxt_state.load_done = 1'b0;

    // Read data captured during the wait cycle
    nxt_state.rdata = RESET_BYTE;
    if (hit(idx, IDX_PERIOD))   nxt_state.rdata = state_ff.period;
    if (hit(idx, IDX_CMP0))     nxt_state.rdata = state_ff.cmp_lo[0 +: 8];
    if (hit(idx, IDX_CMP1))     nxt_state.rdata = state_ff.cmp_lo[8 +: 8];
    if (hit(idx, IDX_CMP2))     nxt_state.rdata = state_ff.cmp_lo[16 +: 8];
    if (hit(idx, IDX_CMP3))     nxt_state.rdata = state_ff.cmp_lo[24 +: 8];
    if (hit(idx, IDX_CTRL1))    nxt_state.rdata = state_ff.ctrl1;
    if (hit(idx, IDX_CTRL2))    nxt_state.rdata = state_ff.ctrl2;
    if (hit(idx, IDX_PER_HI))   nxt_state.rdata = {6'h00, state_ff.per_hi};
    if (hit(idx, IDX_CMP_HI))   nxt_state.rdata = state_ff.cmp_hi;
    if (hit(idx, IDX_IRQ_STAT)) nxt_state.rdata = {6'h00, state_ff.irq_stat};
    if (hit(idx, IDX_IRQ_MASK)) nxt_state.rdata = {6'h00, state_ff.irq_mask};

    // Software writes
    if (wr_acc) begin
      if (hit(idx, IDX_PERIOD)) nxt_state.period = wbyte;
      if (hit(idx, IDX_CMP0))   nxt_state.cmp_lo[0 +: 8]  = wbyte;
      if (hit(idx, IDX_CMP1))   nxt_state.cmp_lo[8 +: 8]  = wbyte;
      if (hit(idx, IDX_CMP2))   nxt_state.cmp_lo[16 +: 8] = wbyte;
      if (hit(idx, IDX_CMP3))   nxt_state.cmp_lo[24 +: 8] = wbyte;
      if (hit(idx, IDX_CTRL2))  nxt_state.ctrl2 = wbyte;
      if (hit(idx, IDX_PER_HI)) nxt_state.per_hi = wbyte[1:0];
      if (hit(idx, IDX_CMP_HI)) nxt_state.cmp_hi = wbyte;
      if (hit(idx, IDX_IRQ_MASK)) nxt_state.irq_mask = wbyte[IRQ_W-1:0];
      if (hit(idx, IDX_IRQ_STAT))
        nxt_state.irq_stat = state_ff.irq_stat & ~wbyte[IRQ_W-1:0];
      if (hit(idx, IDX_CTRL1)) begin
        nxt_state.ctrl1[C1_RUN]  = wbyte[C1_RUN];
        nxt_state.ctrl1[C1_LOAD] = wbyte[C1_LOAD];
        nxt_state.ctrl1[C1_UF]   = state_ff.ctrl1[C1_UF] & wbyte[C1_UF];
        nxt_state.ctrl1[C1_CLR]  = 1'b0;
        nxt_state.ctrl1[NCH-1:0] = wbyte[NCH-1:0];
      end
    end

    // Counter
    if (underflow) begin
      nxt_state.ctrl1[C1_UF]   = 1'b1;
      nxt_state.irq_stat[IRQ_UF] = 1'b1;
      if (state_ff.ctrl1[C1_LOAD]) begin
        nxt_state.counter   = {state_ff.per_hi, state_ff.period};
        for (int i = 0; i < NCH; i++) begin
          nxt_state.cmp_work[i*CNT_W +: CNT_W] =
            {state_ff.cmp_hi[2*i +: 2], state_ff.cmp_lo[8*i +: 8]};
        end
        nxt_state.load_done = 1'b1;
      end else begin
        nxt_state.counter = CNT_WRAP;
      end
    end else if (state_ff.ctrl1[C1_RUN]) begin
      nxt_state.counter = state_ff.counter - 10'h001;
    end
    if (state_ff.load_done) nxt_state.ctrl1[C1_LOAD] = 1'b0;
    if (wr_acc && hit(idx, IDX_CTRL1) && wbyte[C1_CLR])
      nxt_state.counter = CNT_ZERO;

    // Pin brake stops the counter and raises the sticky flag
    if (pin_brake) begin
      nxt_state.ctrl1[C1_RUN]     = 1'b0;
      nxt_state.irq_stat[IRQ_PIN] = 1'b1;
    end

    // Outputs
    if (brake)
      nxt_state.pwm = state_ff.ctrl2[NCH-1:0];
    else if (state_ff.ctrl1[C1_RUN])
      nxt_state.pwm = raw ^ state_ff.ctrl1[NCH-1:0];
    else
      nxt_state.pwm = state_ff.ctrl1[NCH-1:0];
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pwm_out = state_ff.pwm;
  assign irq_out = |(state_ff.irq_stat & state_ff.irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  logic clr_wr;
  assign clr_wr = wr_acc && hit(idx, IDX_CTRL1);

  sequence s_load_uf;
    underflow && state_ff.ctrl1[C1_LOAD] && !clr_wr;
  endsequence

  a_run_hold: assert property (
    !state_ff.ctrl1[C1_RUN] && !clr_wr |=> $stable(state_ff.counter))
    else $error("counter moved while stopped");
  a_load_xfer: assert property (
    s_load_uf |=> state_ff.counter == $past({state_ff.per_hi,
                                             state_ff.period}))
    else $error("period not loaded at underflow");
  a_load_clear: assert property (
    s_load_uf ##1 !clr_wr |=> !state_ff.ctrl1[C1_LOAD])
    else $error("load bit not cleared");
  a_no_load: assert property (
    underflow && !state_ff.ctrl1[C1_LOAD] && !clr_wr
    |=> state_ff.counter == CNT_WRAP && $stable(state_ff.cmp_work))
    else $error("load happened with load bit clear");
  a_uf_flag: assert property (
    underflow |=> state_ff.ctrl1[C1_UF] && state_ff.irq_stat[IRQ_UF])
    else $error("underflow flag not set");
  a_cnt_clear: assert property (
    clr_wr && wbyte[C1_CLR] |=> state_ff.counter == CNT_ZERO)
    else $error("counter clear failed");
  a_brake_off: assert property (
    !state_ff.ctrl2[C2_EN] |-> !brake)
    else $error("brake while disabled");
  a_brake_lvl: assert property (
    brake |=> pwm_out == $past(state_ff.ctrl2[NCH-1:0]))
    else $error("brake level not driven");
  a_pin_stop: assert property (
    pin_brake |=> !state_ff.ctrl1[C1_RUN] && state_ff.irq_stat[IRQ_PIN])
    else $error("pin brake did not stop");
  a_irq_gate: assert property (
    state_ff.irq_stat[IRQ_PIN] && !state_ff.irq_mask[IRQ_PIN] &&
    !(state_ff.irq_stat[IRQ_UF] && state_ff.irq_mask[IRQ_UF]) |-> !irq_out)
    else $error("interrupt not gated");
endmodule

// ===== test/pwmb_stage_model.sv
// Power stage model: watches PWM channel 0 of the four lines, drives the brake pin.
// Assumes fault_in and pol_in change only right after a rising edge.
`timescale 1ns/1ps
module pwmb_stage_model (
  input  wire logic       clk_in,
  input  wire logic [3:0] drive_in,
  input  wire logic       fault_in,
  input  wire logic       pol_in,
  output logic            brake_pin_out,
  output logic [11:0]     pulse_len_out,
  output logic [7:0]      pulse_cnt_out
);
  logic [11:0] run_len;
  // Pin sits at the inactive level unless a fault is commanded
  assign brake_pin_out = fault_in ? pol_in : ~pol_in;
  initial begin
    run_len = 12'h000;
    pulse_len_out = 12'h000;
    pulse_cnt_out = 8'h00;
  end
  // Length of the last completed high pulse on channel 0
  always @(posedge clk_in) begin
    if (drive_in[0] === 1'b1) begin
      run_len <= run_len + 12'h001;
    end else if (run_len != 12'h000) begin
      pulse_len_out <= run_len;
      pulse_cnt_out <= pulse_cnt_out + 8'h01;
      run_len <= 12'h000;
    end
  end
endmodule

// ===== test/test_four_channel_pwm_with_brake.sv
// Self-checking bench for the four-channel PWM with brake.
// Assumes pwmb_top with Avalon-MM registers and the stage model.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module test_four_channel_pwm_with_brake;
  import pwmb_pkg::*;
  logic        clk, rst, rd, we, fault, pol;
  logic [9:0]  adr;
  logic [31:0] wd;
  logic [31:0] rdata;
  logic        wait_o, brk_pin, irq;
  logic [3:0]  pwm;
  logic [11:0] plen;
  logic [7:0]  pcnt, q;
  int          n_errors, n_tests, cyc;

  pwmb_top i_dut (.core_clk_in(clk), .reset_in(rst), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(we), .avs_byteenable_in(4'hf),
    .avs_writedata_in(wd), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_o), .brake_pin_in(brk_pin), .pwm_out(pwm),
    .irq_out(irq));
  pwmb_stage_model i_stage (.clk_in(clk), .drive_in(pwm), .fault_in(fault),
    .pol_in(pol), .brake_pin_out(brk_pin), .pulse_len_out(plen),
    .pulse_cnt_out(pcnt));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= {idx, 2'b00};
    wd  <= {24'h000000, d};
    rd  <= !w;
    we  <= w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_o !== 1'b0 && n < 50);
    if (n >= 50) n_errors++;
    q = rdata[7:0];
    rd <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] m,
                        input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    `CHK(q & m, e)
  endtask
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask
  task automatic wait_pulse();
    int n;
    logic [7:0] c0;
    n = 0;
    c0 = pcnt;
    while (pcnt == c0 && n < 1200) begin
      @(negedge clk);
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    `CHK(pwm, 4'h0)
    rd_chk(IDX_CTRL1, 8'hff, 8'h00);
    wr(IDX_PERIOD, 8'h5a);
    rd_chk(IDX_PERIOD, 8'hff, 8'h5a);
    wr(IDX_CMP2, 8'ha5);
    rd_chk(IDX_CMP2, 8'hff, 8'ha5);
    wr(8'h10, 8'hff);
    rd_chk(8'h10, 8'hff, 8'h00);
  endtask
  task automatic t_brake_soft();
    wr(IDX_CTRL1, 8'h05);
    settle();
    `CHK(pwm, 4'h5)
    wr(IDX_CTRL2, 8'h0a);
    settle();
    `CHK(pwm, 4'h5)
    wr(IDX_CTRL2, 8'h1a);
    settle();
    `CHK(pwm, 4'ha)
    wr(IDX_CTRL2, 8'h93);
    settle();
    `CHK(pwm, 4'h3)
    wr(IDX_CTRL1, 8'h85);
    rd_chk(IDX_CTRL1, 8'h80, 8'h80);
    wr(IDX_CTRL1, 8'h00);
    wr(IDX_CTRL2, 8'h00);
  endtask
  task automatic t_counter();
    wr(IDX_PERIOD, 8'h10);
    wr(IDX_CMP0, 8'h08);
    wr(IDX_CTRL1, 8'hd0);
    wait_pulse();
    `CHK(plen, 12'h008)
    rd_chk(IDX_CTRL1, 8'hff, 8'ha0);
    wr(IDX_CTRL1, 8'h80);
    rd_chk(IDX_CTRL1, 8'h20, 8'h00);
    wr(IDX_CMP0, 8'h20);
    wait_pulse();
    `CHK(plen, 12'h008)
    wr(IDX_CTRL1, 8'h00);
  endtask
  task automatic t_pin();
    pol <= 1'b1;
    wr(IDX_IRQ_MASK, 8'h00);
    wr(IDX_IRQ_STAT, 8'h03);
    wr(IDX_CTRL2, 8'h76);
    wr(IDX_CTRL1, 8'h80);
    fault <= 1'b1;
    settle();
    `CHK(pwm, 4'h6)
    rd_chk(IDX_CTRL1, 8'h80, 8'h00);
    rd_chk(IDX_IRQ_STAT, 8'h02, 8'h02);
    `CHK(irq, 1'b0)
    wr(IDX_IRQ_MASK, 8'h02);
    settle();
    `CHK(irq, 1'b1)
    fault <= 1'b0;
    wr(IDX_IRQ_STAT, 8'h02);
    settle();
    `CHK(irq, 1'b0)
    pol <= 1'b0;
    wr(IDX_CTRL2, 8'h36);
    fault <= 1'b1;
    settle();
    `CHK(pwm, 4'h6)
    wr(IDX_CTRL2, 8'hb6);
    wr(IDX_CTRL1, 8'h80);
    settle();
    rd_chk(IDX_CTRL1, 8'h80, 8'h80);
    fault <= 1'b0;
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    rd = 1'b0;
    we = 1'b0;
    adr = 10'h000;
    wd = 32'h00000000;
    fault = 1'b0;
    pol = 1'b1;
    n_errors = 0;
    n_tests = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_brake_soft();
    t_counter();
    t_pin();
    wrap_up();
  end
endmodule
